// [hw/usc_consts.svh]
// Register map, field positions, reset values and rate constants of the serial configuration block.
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH
`define USC_ADDR_W         8
`define USC_ADDR_CTRL_A    8'h00
`define USC_ADDR_CTRL_B    8'h04
`define USC_ADDR_CTRL_C    8'h08
`define USC_ADDR_DIV_HIGH  8'h0c
`define USC_ADDR_DIV_LOW   8'h10
`define USC_ADDR_DATA      8'h14
`define USC_ADDR_STATUS    8'h18
`define USC_BIT_DSPEED     1
`define USC_BIT_RX_EN      4
`define USC_BIT_TX_EN      3
`define USC_BIT_SIZE_HI    2
`define USC_BIT_POL        0
`define USC_LSB_SIZE_LO    1
`define USC_BIT_STOP       3
`define USC_LSB_MODE       6
`define USC_MODE_SYNC      2'h1
`define USC_RST_CTRL_C     8'h06
`define USC_RST_DIV_HIGH   4'h0
`define USC_RST_DIV_LOW    8'h00
`define USC_DIV_W          12
`define USC_OS_NORMAL      4'hf
`define USC_OS_DOUBLE      4'h7
`define USC_CHAR_W         9
`define USC_FIFO_DEPTH     32
`define USC_RESP_OKAY      2'h0
`define USC_RESP_SLVERR    2'h2
`endif

// [hw/usc_pkg.sv]
// Types shared by the serial configuration block.
package usc_pkg;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } usc_tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } usc_rx_state_t;
  typedef struct packed {
    logic       sync;
    logic       pol;
    logic       two_stop;
    logic       dspeed;
    logic [2:0] size_code;
  } usc_frame_cfg_t;
endpackage

// [hw/usc_top.sv]
// Serial transceiver with frame format and baud divisor registers over AXI4-Lite.
`timescale 1ns/10ps
`include "usc_consts.svh"
// Notes on behaviour
// - Transmitter sends one stop bit when stop select is 0, two when 1.
// - Receiver checks one stop bit whatever the stop select bit says.
// - Size code 000..011 gives 5..8 data bits, 111 gives 9; 100..110 reserved.
// - Sync polarity 0 launches on rising, samples on falling clock; 1 swaps.
// - Divisor is 12 bits: high register holds 11:8, low register 7:0.
// - Writing the low divisor byte reloads the prescaler at once.
// - High register bits 15:12 read zero, are read-only; software writes zero.
// - Divisor zero gives clock/16 normal, clock/8 double speed.
// - Double speed cuts divider from 16 to 8; ignored in sync mode.
// - Size high bit lives in control B, low two bits in control C.
module usc_fifo #(
  parameter int W = 9,
  parameter int D = 32
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = ce && (cnt_q != (AW+1)'(D));
  assign out_valid = ce && (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
endmodule

module usc_top (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             sync_clock_pin_o,
  output logic             sync_clock_pin_oe
);
  function automatic logic addr_ok(input logic [7:0] a);
    return a <= `USC_ADDR_STATUS && a[1:0] == 2'h0;
  endfunction

  // Reserved size codes fall back to eight bits so a frame stays well formed.
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0:    return 4'h5;
      3'h1:    return 4'h6;
      3'h2:    return 4'h7;
      3'h7:    return 4'h9;
      default: return 4'h8;
    endcase
  endfunction

  logic [7:0]  aw_addr_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic        w_strb0_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_mux;
  logic        wr_go;
  logic        wr_low;
  logic        rd_go;
  logic        ds_q;
  logic        rx_en_q;
  logic        tx_en_q;
  logic        size_hi_q;
  logic [7:0]  ctrl_c_q;
  logic [3:0]  div_hi_q;
  logic [7:0]  div_lo_q;
  logic [11:0] presc_q;
  logic        tick;
  logic        xck_q;
  logic        launch;
  logic        sample;
  logic [3:0]  os_m1;
  logic [3:0]  nbits;
  usc_pkg::usc_frame_cfg_t cfg;
  usc_pkg::usc_tx_state_t  tx_st_q;
  logic [3:0]  tcnt_q;
  logic [3:0]  tbit_q;
  logic [8:0]  tsh_q;
  logic        tx_out_q;
  logic        tx_step;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [8:0]  fifo_out_data;
  usc_pkg::usc_rx_state_t  rx_st_q;
  logic        rin_m_q;
  logic        rin_q;
  logic [3:0]  rcnt_q;
  logic [3:0]  rbit_q;
  logic [8:0]  rsh_q;
  logic [8:0]  rx_data_q;
  logic        rx_valid_q;
  logic        ferr_q;
  logic        rx_step;

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = ce && !aw_have_q;
  assign s_axi_wready  = ce && !w_have_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  // A data write waits while the transmit FIFO is full, stalling the master.
  assign wr_go  = ce && aw_have_q && w_have_q && !bvalid_q
                  && (aw_addr_q != `USC_ADDR_DATA || fifo_in_ready);
  assign wr_low = wr_go && w_strb0_q && aw_addr_q == `USC_ADDR_DIV_LOW;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `USC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q  <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= addr_ok(aw_addr_q) ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ds_q      <= 1'b0;
      rx_en_q   <= 1'b0;
      tx_en_q   <= 1'b0;
      size_hi_q <= 1'b0;
      ctrl_c_q  <= `USC_RST_CTRL_C;
      div_hi_q  <= `USC_RST_DIV_HIGH;
      div_lo_q  <= `USC_RST_DIV_LOW;
    end else if (wr_go && w_strb0_q) begin
      case (aw_addr_q)
        `USC_ADDR_CTRL_A: ds_q <= w_data_q[`USC_BIT_DSPEED];
        `USC_ADDR_CTRL_B: begin
          rx_en_q   <= w_data_q[`USC_BIT_RX_EN];
          tx_en_q   <= w_data_q[`USC_BIT_TX_EN];
          size_hi_q <= w_data_q[`USC_BIT_SIZE_HI];
        end
        `USC_ADDR_CTRL_C:   ctrl_c_q <= w_data_q[7:0];
        `USC_ADDR_DIV_HIGH: div_hi_q <= w_data_q[3:0];
        `USC_ADDR_DIV_LOW:  div_lo_q <= w_data_q[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    cfg.sync      = ctrl_c_q[`USC_LSB_MODE +: 2] == `USC_MODE_SYNC;
    cfg.pol       = ctrl_c_q[`USC_BIT_POL];
    cfg.two_stop  = ctrl_c_q[`USC_BIT_STOP];
    cfg.dspeed    = ds_q;
    cfg.size_code = {size_hi_q, ctrl_c_q[`USC_LSB_SIZE_LO +: 2]};
  end

  assign nbits = char_bits(cfg.size_code);
  assign os_m1 = cfg.dspeed ? `USC_OS_DOUBLE : `USC_OS_NORMAL;

  // Prescaler counts the divisor down; one tick per divisor-plus-one clocks.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      presc_q <= 12'h000;
    end else if (ce) begin
      if (wr_low) begin
        presc_q <= {div_hi_q, w_data_q[7:0]};
      end else if (presc_q == 12'h000) begin
        presc_q <= {div_hi_q, div_lo_q};
      end else begin
        presc_q <= presc_q - 12'h001;
      end
    end
  end

  assign tick = ce && presc_q == 12'h000;

  // Synchronous clock runs free in sync mode so the receiver can work alone.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      xck_q <= 1'b0;
    end else if (ce) begin
      if (!cfg.sync) begin
        xck_q <= 1'b0;
      end else if (tick) begin
        xck_q <= !xck_q;
      end
    end
  end

  assign sync_clock_pin_o  = xck_q;
  assign sync_clock_pin_oe = cfg.sync;
  assign launch = tick && cfg.sync && (xck_q == cfg.pol);
  assign sample = tick && cfg.sync && (xck_q != cfg.pol);
  // Double speed has no effect in sync mode: the bit rate follows the clock.
  assign tx_step = cfg.sync ? launch : (tick && tcnt_q == os_m1);
  assign rx_step = cfg.sync ? sample : (tick && rcnt_q == os_m1);

  usc_fifo #(
    .W(`USC_CHAR_W),
    .D(`USC_FIFO_DEPTH)
  ) u_txfifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (wr_go && aw_addr_q == `USC_ADDR_DATA),
    .in_ready  (fifo_in_ready),
    .in_data   (w_data_q[8:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = tx_st_q == usc_pkg::TX_IDLE && tx_en_q
                          && (cfg.sync ? launch : tick);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_st_q  <= usc_pkg::TX_IDLE;
      tcnt_q   <= 4'h0;
      tbit_q   <= 4'h0;
      tsh_q    <= 9'h000;
      tx_out_q <= 1'b1;
    end else if (ce) begin
      if (tick) begin
        tcnt_q <= (tcnt_q == os_m1) ? 4'h0 : 4'(tcnt_q + 1'b1);
      end
      case (tx_st_q)
        usc_pkg::TX_IDLE: begin
          if (fifo_out_valid && fifo_out_ready) begin
            tx_st_q  <= usc_pkg::TX_START;
            tsh_q    <= fifo_out_data;
            tx_out_q <= 1'b0;
            tcnt_q   <= 4'h0;
          end
        end
        usc_pkg::TX_START: begin
          if (tx_step) begin
            tx_st_q  <= usc_pkg::TX_DATA;
            tx_out_q <= tsh_q[0];
            tsh_q    <= {1'b0, tsh_q[8:1]};
            tbit_q   <= 4'h0;
          end
        end
        usc_pkg::TX_DATA: begin
          if (tx_step && tbit_q == 4'(nbits - 1'b1)) begin
            tx_st_q  <= usc_pkg::TX_STOP;
            tx_out_q <= 1'b1;
            tbit_q   <= 4'h0;
          end else if (tx_step) begin
            tx_out_q <= tsh_q[0];
            tsh_q    <= {1'b0, tsh_q[8:1]};
            tbit_q   <= 4'(tbit_q + 1'b1);
          end
        end
        usc_pkg::TX_STOP: begin
          if (tx_step && tbit_q == {3'h0, cfg.two_stop}) begin
            tx_st_q <= usc_pkg::TX_IDLE;
          end else if (tx_step) begin
            tbit_q <= 4'(tbit_q + 1'b1);
          end
        end
        default: tx_st_q <= usc_pkg::TX_IDLE;
      endcase
    end
  end

  assign serial_out_pin = tx_out_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rin_m_q <= 1'b1;
      rin_q   <= 1'b1;
    end else if (ce) begin
      rin_m_q <= serial_in_pin;
      rin_q   <= rin_m_q;
    end
  end

  // Received character is kept until the next frame replaces it; a new frame that lands on the read wins.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_st_q    <= usc_pkg::RX_IDLE;
      rcnt_q     <= 4'h0;
      rbit_q     <= 4'h0;
      rsh_q      <= 9'h000;
      rx_data_q  <= 9'h000;
      rx_valid_q <= 1'b0;
      ferr_q     <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        rcnt_q <= (rcnt_q == os_m1) ? 4'h0 : 4'(rcnt_q + 1'b1);
      end
      if (rd_go && s_axi_araddr == `USC_ADDR_DATA) begin
        rx_valid_q <= 1'b0;
      end
      case (rx_st_q)
        usc_pkg::RX_IDLE: begin
          rsh_q  <= 9'h000;
          rbit_q <= 4'h0;
          if (rx_en_q && !rin_q && cfg.sync && sample) begin
            rx_st_q <= usc_pkg::RX_DATA;
          end else if (rx_en_q && !rin_q && !cfg.sync && tick) begin
            rx_st_q <= usc_pkg::RX_START;
            // Start the count half a bit in so each sample lands mid-bit.
            rcnt_q  <= {1'b0, os_m1[3:1]};
          end
        end
        usc_pkg::RX_START: begin
          if (rx_step) begin
            rx_st_q <= rin_q ? usc_pkg::RX_IDLE : usc_pkg::RX_DATA;
          end
        end
        usc_pkg::RX_DATA: begin
          if (rx_step) begin
            rsh_q[rbit_q] <= rin_q;
            rbit_q        <= 4'(rbit_q + 1'b1);
            if (rbit_q == 4'(nbits - 1'b1)) begin
              rx_st_q <= usc_pkg::RX_STOP;
            end
          end
        end
        usc_pkg::RX_STOP: begin
          if (rx_step) begin
            rx_st_q    <= usc_pkg::RX_IDLE;
            rx_data_q  <= rsh_q;
            ferr_q     <= !rin_q;
            rx_valid_q <= 1'b1;
          end
        end
        default: rx_st_q <= usc_pkg::RX_IDLE;
      endcase
    end
  end

  // Read channel.
  assign s_axi_arready = ce && !rvalid_q;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rd_mux = 32'h0;
    case (s_axi_araddr)
      `USC_ADDR_CTRL_A:   rd_mux[`USC_BIT_DSPEED] = ds_q;
      `USC_ADDR_CTRL_B:   rd_mux[7:0] = {3'h0, rx_en_q, tx_en_q, size_hi_q, 2'h0};
      `USC_ADDR_CTRL_C:   rd_mux[7:0] = ctrl_c_q;
      `USC_ADDR_DIV_HIGH: rd_mux[3:0] = div_hi_q;
      `USC_ADDR_DIV_LOW:  rd_mux[7:0] = div_lo_q;
      `USC_ADDR_DATA:     rd_mux[8:0] = rx_data_q;
      `USC_ADDR_STATUS:   rd_mux[4:0] = {tx_st_q != usc_pkg::TX_IDLE, !fifo_in_ready,
                                         !fifo_out_valid, ferr_q, rx_valid_q};
      default:            rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `USC_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= addr_ok(s_axi_araddr) ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_PRESC_RELOAD: assert property (wr_low |=> presc_q == {div_hi_q, div_lo_q})
    else $error("Low divisor write did not reload the prescaler.");
  AST_PRESC_WRAP: assert property (ce && presc_q == 12'h000 && !wr_low
                                   |=> presc_q == $past({div_hi_q, div_lo_q}))
    else $error("Prescaler did not restart from the divisor.");
  AST_HIGH_RD_ZERO: assert property (rd_go && s_axi_araddr == `USC_ADDR_DIV_HIGH
                                     |=> rvalid_q && rdata_q[31:4] == 28'h0)
    else $error("Divisor high read shows nonzero upper bits.");
  AST_STOP_COUNT: assert property ($fell(tx_st_q == usc_pkg::TX_STOP)
                                   |-> $past(tbit_q) == {3'h0, $past(cfg.two_stop)})
    else $error("Wrong number of stop bits sent.");
  AST_STOP_HIGH: assert property (tx_st_q == usc_pkg::TX_STOP |-> serial_out_pin)
    else $error("Stop bit is not high.");
  AST_DATA_LEN: assert property ($fell(tx_st_q == usc_pkg::TX_DATA)
                                 |-> $past(tbit_q) == 4'($past(nbits) - 1'b1))
    else $error("Transmitted character length does not match size code.");
  AST_RX_ONE_STOP: assert property (rx_st_q == usc_pkg::RX_STOP && rx_step
                                    |=> rx_st_q == usc_pkg::RX_IDLE && rx_valid_q)
    else $error("Receiver did not finish after one stop bit.");
  AST_SYNC_LAUNCH: assert property (cfg.sync && tx_step && tx_st_q != usc_pkg::TX_IDLE
                                    |=> sync_clock_pin_o == !cfg.pol)
    else $error("Transmit data changed on the wrong clock edge.");
  AST_ASYNC_BIT: assert property (!cfg.sync && tx_st_q == usc_pkg::TX_START && tick
                                  |-> tcnt_q <= os_m1)
    else $error("Async bit counter passed the oversample limit.");
  AST_ASYNC_NOCLK: assert property (!cfg.sync && !$past(cfg.sync)
                                    |-> !sync_clock_pin_oe && !sync_clock_pin_o)
    else $error("Sync clock driven in async mode.");

  COV_TWO_STOP: cover property (tx_st_q == usc_pkg::TX_STOP && cfg.two_stop && tx_step);
  COV_NINE_BITS: cover property (rx_valid_q && nbits == 4'h9);
  COV_SYNC_TX: cover property (cfg.sync && tx_st_q == usc_pkg::TX_DATA);
  COV_FIFO_FULL: cover property (!fifo_in_ready && ce);
endmodule

// [sim/usc_remote.sv]
// Remote serial transceiver model that decodes device frames and sends frames to the device.
`timescale 1ns/10ps
module usc_remote (
  input  wire logic        core_clk,
  input  wire logic        line_in,
  output logic             line_out,
  input  wire logic [15:0] bit_clks,
  input  wire logic [3:0]  nbits
);
  logic [8:0] got_ch;
  logic       got_stop;
  int         got_cnt = 0;
  int         period;
  time        last_t = 0;
  initial line_out = 1'b1;
  // Sampling on the falling edge keeps clear of the device's own launch edge.
  initial forever begin
    @(negedge core_clk iff line_in === 1'b0);
    period = int'(($time - last_t) / 25);
    last_t = $time;
    got_ch = '0;
    repeat (bit_clks / 2) @(negedge core_clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(negedge core_clk);
      got_ch[i] = line_in;
    end
    repeat (bit_clks) @(negedge core_clk);
    got_stop = line_in;
    got_cnt++;
  end
  task automatic send(input logic [8:0] c, input int n, input int stops);
    @(posedge core_clk);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      line_out <= c[i];
      repeat (bit_clks) @(posedge core_clk);
    end
    line_out <= 1'b1;
    repeat (bit_clks * stops) @(posedge core_clk);
  endtask
endmodule

// [sim/usart_frame_and_baud_config_tb.sv]
// Register-level testbench for the serial frame and baud configuration block.
`timescale 1ns/10ps
`include "usc_consts.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module usart_frame_and_baud_config_tb;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_val;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        rx_line, tx_line, sclk, sclk_oe;
  logic [15:0] bt = 16'h0010;
  logic [3:0]  nb = 4'h8;
  logic        chk_sync = 1'b0, pol = 1'b0, prev_out = 1'b1, prev_clk = 1'b0;
  int          error_cnt = 0, cmp_count = 0, cyc_cnt = 0, toggles, n0;
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [8:0]  ch0, ch1, mask;
  int          stp, ds;
  initial forever #12.5 core_clk = ~core_clk;
  usc_top i_dut (.core_clk(core_clk), .reset(reset), .ce(1'b1), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line), .sync_clock_pin_o(sclk),
    .sync_clock_pin_oe(sclk_oe));
  usc_remote i_remote (.core_clk(core_clk), .line_in(tx_line), .line_out(rx_line),
    .bit_clks(bt), .nbits(nb));
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge core_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    `CHK(bresp, er)
    // One idle edge keeps a following call from raising bready in this time step.
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic ta, tr;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge core_clk);
      ta = arvalid & arready;
      tr = rvalid;
      rd_val = rdata;
      @(posedge core_clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    `CHK(rresp, er)
    // One idle edge keeps a following call from raising rready in this time step.
    @(posedge core_clk);
  endtask
  // Watches that the data line moves only on the launch edge of the synchronous clock.
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
    if (chk_sync && tx_line !== prev_out) begin
      toggles++;
      `CHK(sclk !== prev_clk && sclk === ~pol, 1'b1)
    end
    prev_out = tx_line;
    prev_clk = sclk;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(`USC_ADDR_DIV_HIGH, `USC_RESP_OKAY);
    `CHK(rd_val, 32'h0)
    rd(`USC_ADDR_DIV_LOW, `USC_RESP_OKAY);
    `CHK(rd_val, 32'h0)
    wr(`USC_ADDR_DIV_HIGH, 32'hff, `USC_RESP_OKAY);
    rd(`USC_ADDR_DIV_HIGH, `USC_RESP_OKAY);
    `CHK(rd_val, 32'h0f)
    wr(`USC_ADDR_DIV_LOW, 32'hab, `USC_RESP_OKAY);
    rd(`USC_ADDR_DIV_LOW, `USC_RESP_OKAY);
    `CHK(rd_val, 32'hab)
    wr(8'h40, 32'h1, `USC_RESP_SLVERR);
    rd(8'h40, `USC_RESP_SLVERR);
    wr(`USC_ADDR_DIV_HIGH, 32'h0, `USC_RESP_OKAY);
    // Two frames back to back per size code; the start-to-start gap is the whole frame
    // plus the one prescaler tick that the transmitter spends idle before the next pop.
    for (int i = 0; i < 5; i++) begin
      ds = i % 2;
      stp = (i >> 1) & 1;
      nb <= 4'(5 + i);
      bt <= 16'((i + 1) * (ds ? 8 : 16));
      mask = 9'((1 << (5 + i)) - 1);
      ch0 = 9'h1a5 ^ 9'(i);
      ch1 = 9'h05a + 9'(i);
      wr(`USC_ADDR_CTRL_A, 32'(ds) << `USC_BIT_DSPEED, `USC_RESP_OKAY);
      wr(`USC_ADDR_CTRL_B, (32'h1 << `USC_BIT_TX_EN) | (32'(codes[i][2]) << `USC_BIT_SIZE_HI),
        `USC_RESP_OKAY);
      wr(`USC_ADDR_CTRL_C, (32'(stp) << `USC_BIT_STOP) | (32'(codes[i][1:0]) << 1),
        `USC_RESP_OKAY);
      wr(`USC_ADDR_DIV_LOW, 32'(i), `USC_RESP_OKAY);
      n0 = i_remote.got_cnt;
      wr(`USC_ADDR_DATA, 32'(ch0), `USC_RESP_OKAY);
      wr(`USC_ADDR_DATA, 32'(ch1), `USC_RESP_OKAY);
      wait (i_remote.got_cnt == n0 + 2);
      `CHK(i_remote.got_ch, ch1 & mask)
      `CHK(i_remote.period, (7 + i + stp) * int'(bt) + i + 1)
      `CHK(i_remote.got_stop, 1'b1)
      repeat (3 * bt) @(posedge core_clk);
    end
    // The receiver must take a one-stop frame even with two stops selected.
    nb <= 4'h8;
    bt <= 16'h0010;
    wr(`USC_ADDR_CTRL_A, 32'h0, `USC_RESP_OKAY);
    wr(`USC_ADDR_CTRL_B, 32'h1 << `USC_BIT_RX_EN, `USC_RESP_OKAY);
    wr(`USC_ADDR_CTRL_C, 32'h0e, `USC_RESP_OKAY);
    wr(`USC_ADDR_DIV_LOW, 32'h0, `USC_RESP_OKAY);
    i_remote.send(9'h03c, 8, 1);
    rd(`USC_ADDR_STATUS, `USC_RESP_OKAY);
    `CHK(rd_val[0], 1'b1)
    rd(`USC_ADDR_DATA, `USC_RESP_OKAY);
    `CHK(rd_val[8:0], 9'h03c)
    // Synchronous mode with both clock polarities.
    for (int p = 0; p < 2; p++) begin
      pol = 1'(p);
      toggles = 0;
      wr(`USC_ADDR_CTRL_B, 32'h1 << `USC_BIT_TX_EN, `USC_RESP_OKAY);
      wr(`USC_ADDR_CTRL_C, 32'h46 | 32'(p), `USC_RESP_OKAY);
      wr(`USC_ADDR_DIV_LOW, 32'h1, `USC_RESP_OKAY);
      chk_sync = 1'b1;
      wr(`USC_ADDR_DATA, 32'h0a5, `USC_RESP_OKAY);
      `CHK(sclk_oe, 1'b1)
      repeat (80) @(posedge core_clk);
      chk_sync = 1'b0;
      `CHK(toggles > 0, 1'b1)
    end
    tally_and_finish();
  end
endmodule
